// ---- hw/fsq_sequencer.v ----
// Sequencer driving flash mode bits for program, prewrite and erase
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fsq_defines.vh"
module fsq_sequencer #(
	parameter [31:0] ERASE_PULSE_CYC = `FSQ_ERASE_PULSE_CYC,
	parameter [31:0] PROG_TOTAL_CYC = `FSQ_PROG_TOTAL_CYC,
	parameter [31:0] ERASE_TOTAL_CYC = `FSQ_ERASE_TOTAL_CYC,
	parameter [31:0] GUARD_DIV = `FSQ_GUARD_DIV,
	parameter [31:0] LOOP_DIV = `FSQ_LOOP_DIV,
	parameter [31:0] RD_LAT = `FSQ_RD_LAT
) (
	input wire clock,
	input wire arst_n,
	input wire [3:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdData,
	output reg irq,
	output reg [15:0] flashAddr,
	output reg [7:0] flashWrData,
	output reg flashWrite,
	output reg flashReadEnable,
	input wire [7:0] flashRdData,
	output reg progBit,
	output reg eraseBit,
	output reg programVerifyBit,
	output reg eraseVerifyBit,
	output reg waitStateEnable,
	output reg ramEmulation
);
	localparam S_IDLE = 4'h0;
	localparam S_WRITE = 4'h1;
	localparam S_PSET = 4'h2;
	localparam S_PULSE = 4'h3;
	localparam S_VWAIT = 4'h4;
	localparam S_RWAIT = 4'h5;
	localparam S_ESET = 4'h6;
	localparam S_EPULSE = 4'h7;
	localparam S_EVWRITE = 4'h8;
	localparam S_EVWAIT = 4'h9;
	localparam S_EVREAD = 4'hA;
	localparam S_EVEND = 4'hB;

	reg [3:0] state_q;
	reg busy_q, prewrite_q;
	reg [15:0] curAddr_q, startAddr_q, endAddr_q;
	reg [7:0] data_q, rdMeta_q, rdSync_q;
	reg [2:0] attempt_q;
	reg [9:0] evCount_q;
	reg [1:0] eraseShift_q;
	reg blockBad_q;
	reg [31:0] progCnt_q, eraseCnt_q, vs1_q, vs2_q;
	reg [15:0] guardSet_q, guard_q;
	reg [`FSQ_ST_WIDTH-1:0] status_q, mask_q;
	reg waitCfg_q, loopMode_q;
	reg [31:0] loopDiv_q, guardDiv_q, progTime_q, eraseTime_q;
	reg loopTick_q, guardTick_q;
	reg cntLoad_q;
	reg [31:0] cntValue_q;
	reg evDone_q, evProgFail_q, evEraseFail_q, evGuard_q, evTime_q;
	wire cntExpired;

	wire wrCtrl = regWrite && (regAddr == `FSQ_REG_CTRL);
	wire startProg = wrCtrl && regWrData[`FSQ_CTRL_PROG] && !busy_q;
	wire startErase = wrCtrl && regWrData[`FSQ_CTRL_ERASE] && !regWrData[`FSQ_CTRL_PROG] && !busy_q;
	wire startAny = startProg || startErase;
	wire cfgWrite = regWrite && !busy_q;
	wire guardOver = guardTick_q && (guard_q == 16'hFFFF);
	wire timeOver = (progTime_q > PROG_TOTAL_CYC) || (eraseTime_q > ERASE_TOTAL_CYC);
	wire abortNow = busy_q && (guardOver || timeOver);
	wire cntTick = loopMode_q ? loopTick_q : 1'b1;
	wire [7:0] expectData = prewrite_q ? `FSQ_PREWRITE_DATA : data_q;
	wire byteDone = (state_q == S_RWAIT) && cntExpired && (rdSync_q == expectData);
	wire rdStatus = regRead && (regAddr == `FSQ_REG_STATUS);
	wire [`FSQ_ST_WIDTH-1:0] events = {evTime_q, evGuard_q, evEraseFail_q, evProgFail_q, evDone_q};
	// Set wins over the clearing read so no event is lost
	wire [`FSQ_ST_WIDTH-1:0] statusD = (rdStatus ? {`FSQ_ST_WIDTH{1'b0}} : status_q) | events;

	fsq_down_counter #(.WIDTH(32)) intervalTimer (
		.clock(clock),
		.arst_n(arst_n),
		.load(cntLoad_q),
		.loadValue(cntValue_q),
		.tick(cntTick),
		.running(),
		.expired(cntExpired)
	);

	// Read data arrives asynchronously from the array
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdMeta_q <= 8'h00;
			rdSync_q <= 8'h00;
		end else begin
			rdMeta_q <= flashRdData;
			rdSync_q <= rdMeta_q;
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			loopDiv_q <= 32'h00000000;
			loopTick_q <= 1'b0;
			guardDiv_q <= 32'h00000000;
			guardTick_q <= 1'b0;
		end else begin
			loopTick_q <= (loopDiv_q >= LOOP_DIV - 32'h00000001);
			loopDiv_q <= (loopDiv_q >= LOOP_DIV - 32'h00000001) ? 32'h00000000 :
				loopDiv_q + 32'h00000001;
			guardTick_q <= (guardDiv_q >= GUARD_DIV - 32'h00000001);
			guardDiv_q <= (startAny || guardDiv_q >= GUARD_DIV - 32'h00000001) ? 32'h00000000 :
				guardDiv_q + 32'h00000001;
		end
	end

	// Guard runs untouched from start to end; nothing pauses it
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			guard_q <= 16'h0000;
			progTime_q <= 32'h00000000;
			eraseTime_q <= 32'h00000000;
		end else if (startAny) begin
			guard_q <= regWrData[`FSQ_CTRL_SLOWCLK] ? `FSQ_GUARD_LO : `FSQ_GUARD_HI;
			progTime_q <= 32'h00000000;
			eraseTime_q <= 32'h00000000;
		end else if (busy_q) begin
			if (guardTick_q)
				guard_q <= guard_q + 16'h0001;
			// Program time budget is per byte
			if (byteDone)
				progTime_q <= 32'h00000000;
			else if (progBit)
				progTime_q <= progTime_q + 32'h00000001;
			if (eraseBit)
				eraseTime_q <= eraseTime_q + 32'h00000001;
		end
	end

	// Timing and address settings are frozen while a sequence runs
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			startAddr_q <= 16'h0000;
			endAddr_q <= 16'h0000;
			data_q <= 8'h00;
			progCnt_q <= `FSQ_PROG_PULSE_CYC;
			eraseCnt_q <= ERASE_PULSE_CYC;
			vs1_q <= `FSQ_VS1_CYC;
			vs2_q <= `FSQ_VS2_CYC;
			guardSet_q <= `FSQ_GUARD_HI;
			mask_q <= {`FSQ_ST_WIDTH{1'b0}};
			waitCfg_q <= 1'b0;
			ramEmulation <= 1'b0;
			loopMode_q <= 1'b0;
		end else if (cfgWrite) begin
			case (regAddr)
				`FSQ_REG_START: startAddr_q <= regWrData[15:0];
				`FSQ_REG_END: endAddr_q <= regWrData[15:0];
				`FSQ_REG_DATA: data_q <= regWrData[7:0];
				`FSQ_REG_PROGCNT: progCnt_q <= regWrData;
				`FSQ_REG_ERASECNT: eraseCnt_q <= regWrData;
				`FSQ_REG_VS1: vs1_q <= regWrData;
				`FSQ_REG_VS2: vs2_q <= regWrData;
				`FSQ_REG_GUARD: guardSet_q <= regWrData[15:0];
				`FSQ_REG_MASK: mask_q <= regWrData[`FSQ_ST_WIDTH-1:0];
				`FSQ_REG_CTRL: begin
					waitCfg_q <= regWrData[`FSQ_CTRL_WAIT];
					ramEmulation <= regWrData[`FSQ_CTRL_EMUL];
					guardSet_q <= regWrData[`FSQ_CTRL_SLOWCLK] ? `FSQ_GUARD_LO : `FSQ_GUARD_HI;
					if (regWrData[`FSQ_CTRL_LOAD]) begin
						case (regWrData[`FSQ_CTRL_PROFILE_HI:`FSQ_CTRL_PROFILE_LO])
							2'h1: begin
								progCnt_q <= `FSQ_RAM16_PROG;
								eraseCnt_q <= `FSQ_RAM16_ERASE;
								vs1_q <= `FSQ_RAM16_VS1;
								vs2_q <= `FSQ_RAM16_VS2;
								loopMode_q <= 1'b1;
							end
							2'h2: begin
								progCnt_q <= `FSQ_EXT10_PROG;
								eraseCnt_q <= `FSQ_EXT10_ERASE;
								vs1_q <= `FSQ_EXT10_VS1;
								vs2_q <= `FSQ_EXT10_VS2;
								loopMode_q <= 1'b1;
							end
							2'h3: begin
								progCnt_q <= `FSQ_SCALE_DN(`FSQ_REF10_PROG);
								eraseCnt_q <= `FSQ_SCALE_DN(`FSQ_REF10_ERASE);
								vs1_q <= `FSQ_SCALE_UP(`FSQ_REF10_VS1);
								vs2_q <= `FSQ_SCALE_UP(`FSQ_REF10_VS2);
								loopMode_q <= 1'b1;
							end
							default: begin
								progCnt_q <= `FSQ_PROG_PULSE_CYC;
								eraseCnt_q <= ERASE_PULSE_CYC;
								vs1_q <= `FSQ_VS1_CYC;
								vs2_q <= `FSQ_VS2_CYC;
								loopMode_q <= 1'b0;
							end
						endcase
					end
				end
				default: begin
				end
			endcase
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			busy_q <= 1'b0;
			prewrite_q <= 1'b0;
			curAddr_q <= 16'h0000;
			attempt_q <= 3'h0;
			evCount_q <= 10'h000;
			eraseShift_q <= 2'h0;
			blockBad_q <= 1'b0;
			cntLoad_q <= 1'b0;
			cntValue_q <= 32'h00000000;
			flashAddr <= 16'h0000;
			flashWrData <= 8'h00;
			flashWrite <= 1'b0;
			flashReadEnable <= 1'b0;
			progBit <= 1'b0;
			eraseBit <= 1'b0;
			programVerifyBit <= 1'b0;
			eraseVerifyBit <= 1'b0;
			evDone_q <= 1'b0;
			evProgFail_q <= 1'b0;
			evEraseFail_q <= 1'b0;
			evGuard_q <= 1'b0;
			evTime_q <= 1'b0;
		end else begin
			cntLoad_q <= 1'b0;
			flashWrite <= 1'b0;
			evDone_q <= 1'b0;
			evProgFail_q <= 1'b0;
			evEraseFail_q <= 1'b0;
			evGuard_q <= 1'b0;
			evTime_q <= 1'b0;
			if (abortNow) begin
				state_q <= S_IDLE;
				busy_q <= 1'b0;
				progBit <= 1'b0;
				eraseBit <= 1'b0;
				programVerifyBit <= 1'b0;
				eraseVerifyBit <= 1'b0;
				flashReadEnable <= 1'b0;
				evGuard_q <= guardOver;
				evTime_q <= !guardOver;
			end else begin
				case (state_q)
					S_IDLE: begin
						if (startAny) begin
							busy_q <= 1'b1;
							prewrite_q <= startErase;
							curAddr_q <= startAddr_q;
							attempt_q <= 3'h0;
							evCount_q <= 10'h000;
							eraseShift_q <= 2'h0;
							state_q <= S_WRITE;
						end
					end
					S_WRITE: begin
						flashAddr <= curAddr_q;
						flashWrData <= expectData;
						flashWrite <= 1'b1;
						state_q <= S_PSET;
					end
					S_PSET: begin
						cntValue_q <= progCnt_q;
						cntLoad_q <= 1'b1;
						attempt_q <= attempt_q + 3'h1;
						state_q <= S_PULSE;
					end
					S_PULSE: begin
						progBit <= !cntExpired;
						if (cntExpired) begin
							programVerifyBit <= !prewrite_q;
							cntValue_q <= vs1_q;
							cntLoad_q <= 1'b1;
							state_q <= S_VWAIT;
						end
					end
					S_VWAIT: begin
						if (cntExpired) begin
							flashReadEnable <= 1'b1;
							cntValue_q <= RD_LAT;
							cntLoad_q <= 1'b1;
							state_q <= S_RWAIT;
						end
					end
					S_RWAIT: begin
						if (cntExpired) begin
							flashReadEnable <= 1'b0;
							programVerifyBit <= 1'b0;
							if (rdSync_q == expectData) begin
								attempt_q <= 3'h0;
								if (!prewrite_q) begin
									busy_q <= 1'b0;
									evDone_q <= 1'b1;
									state_q <= S_IDLE;
								end else if (curAddr_q != endAddr_q) begin
									curAddr_q <= curAddr_q + 16'h0001;
									state_q <= S_WRITE;
								end else begin
									prewrite_q <= 1'b0;
									state_q <= S_ESET;
								end
							end else if (attempt_q >= `FSQ_MAX_PROG_TRIES) begin
								busy_q <= 1'b0;
								evProgFail_q <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								state_q <= S_WRITE;
							end
						end
					end
					S_ESET: begin
						cntValue_q <= eraseCnt_q << eraseShift_q;
						cntLoad_q <= 1'b1;
						state_q <= S_EPULSE;
					end
					S_EPULSE: begin
						eraseBit <= !cntExpired;
						if (cntExpired) begin
							eraseVerifyBit <= 1'b1;
							curAddr_q <= startAddr_q;
							blockBad_q <= 1'b0;
							state_q <= S_EVWRITE;
						end
					end
					S_EVWRITE: begin
						flashAddr <= curAddr_q;
						flashWrData <= `FSQ_ERASED_DATA;
						flashWrite <= 1'b1;
						cntValue_q <= vs2_q;
						cntLoad_q <= 1'b1;
						state_q <= S_EVWAIT;
					end
					S_EVWAIT: begin
						if (cntExpired) begin
							flashReadEnable <= 1'b1;
							cntValue_q <= RD_LAT;
							cntLoad_q <= 1'b1;
							state_q <= S_EVREAD;
						end
					end
					S_EVREAD: begin
						if (cntExpired) begin
							flashReadEnable <= 1'b0;
							if (rdSync_q != `FSQ_ERASED_DATA)
								blockBad_q <= 1'b1;
							if (curAddr_q != endAddr_q) begin
								curAddr_q <= curAddr_q + 16'h0001;
								state_q <= S_EVWRITE;
							end else begin
								state_q <= S_EVEND;
							end
						end
					end
					S_EVEND: begin
						eraseVerifyBit <= 1'b0;
						evCount_q <= evCount_q + 10'h001;
						if (!blockBad_q) begin
							busy_q <= 1'b0;
							evDone_q <= 1'b1;
							state_q <= S_IDLE;
						end else if (evCount_q + 10'h001 >= `FSQ_MAX_ERASE_VERIFY) begin
							busy_q <= 1'b0;
							evEraseFail_q <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							if (eraseShift_q < 2'h3)
								eraseShift_q <= eraseShift_q + 2'h1;
							state_q <= S_ESET;
						end
					end
					default: begin
						state_q <= S_IDLE;
						busy_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Wait states may only take effect once the sequence is over
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			waitStateEnable <= 1'b0;
			status_q <= {`FSQ_ST_WIDTH{1'b0}};
			irq <= 1'b0;
			regRdData <= 32'h00000000;
		end else begin
			waitStateEnable <= waitCfg_q && !busy_q && !startAny;
			status_q <= statusD;
			irq <= |(statusD & mask_q);
			regRdData <= 32'h00000000;
			if (regRead) begin
				case (regAddr)
					`FSQ_REG_CTRL: regRdData <= {24'h000000, loopMode_q, 3'h0,
						ramEmulation, waitCfg_q, 2'h0};
					`FSQ_REG_STATUS: regRdData <= {27'h0000000, status_q};
					`FSQ_REG_MASK: regRdData <= {27'h0000000, mask_q};
					`FSQ_REG_START: regRdData <= {16'h0000, startAddr_q};
					`FSQ_REG_END: regRdData <= {16'h0000, endAddr_q};
					`FSQ_REG_DATA: regRdData <= {24'h000000, data_q};
					`FSQ_REG_PROGCNT: regRdData <= progCnt_q;
					`FSQ_REG_ERASECNT: regRdData <= eraseCnt_q;
					`FSQ_REG_VS1: regRdData <= vs1_q;
					`FSQ_REG_VS2: regRdData <= vs2_q;
					`FSQ_REG_GUARD: regRdData <= {16'h0000, guardSet_q};
					`FSQ_REG_STATE: regRdData <= {12'h000, busy_q, prewrite_q, state_q,
						attempt_q, 1'b0, evCount_q};
					default: regRdData <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ---- hw/fsq_defines.vh ----
// Constants for the flash program and erase sequencer
// What this block does
// - Abort when accumulated program or erase time overruns
// - At most six program pulses per byte
// - Pulse counts truncate; erase pulse doubles per failed verify, up to eight times nominal
// - Verify setup counts round up, never short
// - Untabulated clock: scale the ten megahertz counts
// - On-chip RAM at sixteen megahertz counts
// - External memory at ten megahertz counts
// - Guard timer preload selected by clock range
// - Wait states held off while sequence runs
// - Guard timer spans one fixed uninterrupted sequence
// - Prewrite every byte with zero before erase
// - Emulated RAM area also prewritten with zero
// - Leave program mode, all mode bits low
// - Wait long verify setup before each program or prewrite verify read; erase verify waits the short one
// - Erase verify expects every byte all ones
// - Erase error after 602 failed erase verifies
`ifndef FSQ_DEFINES_VH
`define FSQ_DEFINES_VH

`define FSQ_CLK_MHZ 40
`define FSQ_PROG_PULSE_NS 15800
`define FSQ_ERASE_PULSE_NS 6250000
`define FSQ_VS1_NS 4000
`define FSQ_VS2_NS 2000
`define FSQ_PROG_TOTAL_NS 1000000
`define FSQ_ERASE_TOTAL_MS 30000
`define FSQ_PROG_PULSE_CYC ((`FSQ_PROG_PULSE_NS * `FSQ_CLK_MHZ) / 1000)
`define FSQ_ERASE_PULSE_CYC ((`FSQ_ERASE_PULSE_NS * `FSQ_CLK_MHZ) / 1000)
`define FSQ_VS1_CYC ((`FSQ_VS1_NS * `FSQ_CLK_MHZ + 999) / 1000)
`define FSQ_VS2_CYC ((`FSQ_VS2_NS * `FSQ_CLK_MHZ + 999) / 1000)
`define FSQ_PROG_TOTAL_CYC ((`FSQ_PROG_TOTAL_NS * `FSQ_CLK_MHZ) / 1000)
`define FSQ_ERASE_TOTAL_CYC (`FSQ_ERASE_TOTAL_MS * `FSQ_CLK_MHZ * 1000)

`define FSQ_REF10_PROG 19
`define FSQ_REF10_VS1 7
`define FSQ_REF10_VS2 4
`define FSQ_REF10_ERASE 3906
`define FSQ_SCALE_DN(c) ((`FSQ_CLK_MHZ * (c)) / 10)
`define FSQ_SCALE_UP(c) ((`FSQ_CLK_MHZ * (c) + 9) / 10)

`define FSQ_RAM16_PROG 32'h0000001F
`define FSQ_RAM16_VS1 32'h0000000B
`define FSQ_RAM16_VS2 32'h00000006
`define FSQ_RAM16_ERASE 32'h00001869
`define FSQ_EXT10_PROG 32'h00000006
`define FSQ_EXT10_VS1 32'h00000003
`define FSQ_EXT10_VS2 32'h00000002
`define FSQ_EXT10_ERASE 32'h00000516

`define FSQ_GUARD_HI 16'hA57F
`define FSQ_GUARD_LO 16'hA57E
`define FSQ_GUARD_DIV 65536
`define FSQ_LOOP_DIV 20
`define FSQ_RD_LAT 4

`define FSQ_MAX_PROG_TRIES 3'h6
`define FSQ_MAX_ERASE_VERIFY 10'h25A
`define FSQ_PREWRITE_DATA 8'h00
`define FSQ_ERASED_DATA 8'hFF

`define FSQ_REG_CTRL 4'h0
`define FSQ_REG_STATUS 4'h1
`define FSQ_REG_MASK 4'h2
`define FSQ_REG_START 4'h3
`define FSQ_REG_END 4'h4
`define FSQ_REG_DATA 4'h5
`define FSQ_REG_PROGCNT 4'h6
`define FSQ_REG_ERASECNT 4'h7
`define FSQ_REG_VS1 4'h8
`define FSQ_REG_VS2 4'h9
`define FSQ_REG_GUARD 4'hA
`define FSQ_REG_STATE 4'hB

`define FSQ_CTRL_PROG 0
`define FSQ_CTRL_ERASE 1
`define FSQ_CTRL_WAIT 2
`define FSQ_CTRL_EMUL 3
`define FSQ_CTRL_PROFILE_LO 4
`define FSQ_CTRL_PROFILE_HI 5
`define FSQ_CTRL_LOAD 6
`define FSQ_CTRL_SLOWCLK 7

`define FSQ_ST_DONE 0
`define FSQ_ST_PROGFAIL 1
`define FSQ_ST_ERASEFAIL 2
`define FSQ_ST_GUARD 3
`define FSQ_ST_TIME 4
`define FSQ_ST_WIDTH 5

`endif

// ---- hw/fsq_down_counter.v ----
// Loadable down-counter timing one pulse or wait interval
`timescale 1ns/1ps
module fsq_down_counter #(
	parameter WIDTH = 32
) (
	input wire clock,
	input wire arst_n,
	input wire load,
	input wire [WIDTH-1:0] loadValue,
	input wire tick,
	output reg running,
	output reg expired
);
	reg [WIDTH-1:0] count_q;

	// Expiry seen on the last tick, so a pulse lasts exactly its count
	always @* begin
		expired = running && !load && tick && (count_q <= {{(WIDTH-1){1'b0}}, 1'b1});
	end

	// Zero load still lasts one tick so no interval is skipped
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= {WIDTH{1'b0}};
			running <= 1'b0;
		end else if (load) begin
			count_q <= loadValue;
			running <= 1'b1;
		end else if (expired) begin
			count_q <= {WIDTH{1'b0}};
			running <= 1'b0;
		end else if (running && tick) begin
			count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ---- hw/fsq_placeholder_unused.v ----
// Intentionally empty
`timescale 1ns/1ps

// ---- verification/fsq_flash_model.sv ----
// Behavioural flash array answering the sequencer's mode bits
`timescale 1ns/1ps
module fsq_flash_model (
	input wire clock,
	input wire [15:0] flashAddr,
	input wire [7:0] flashWrData,
	input wire flashWrite,
	input wire flashReadEnable,
	input wire progBit,
	input wire eraseBit,
	input wire stuckEn,
	input wire [7:0] stuckAddr,
	output logic [7:0] flashRdData,
	output int zeroProgs,
	output int progPulses
);
	logic [7:0] mem [0:255];
	logic [7:0] latAddr;
	logic [7:0] latData;
	logic progQ;
	logic eraseQ;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		flashRdData = 8'h5A;
		zeroProgs = 0;
		progPulses = 0;
		progQ = 1'h0;
		eraseQ = 1'h0;
		latAddr = 8'h00;
		latData = 8'h00;
	end
	always @(posedge clock) begin
		progQ <= progBit;
		eraseQ <= eraseBit;
		if (flashWrite) begin
			latAddr <= flashAddr[7:0];
			latData <= flashWrData;
		end
		// Programming only clears bits; a stuck byte never takes data
		if (progBit && !progQ) begin
			progPulses <= progPulses + 1;
			if (latData == 8'h00) zeroProgs <= zeroProgs + 1;
			if (!(stuckEn && latAddr == stuckAddr)) mem[latAddr] <= mem[latAddr] & latData;
		end
		// Whole small array erased at once, coarser than real blocks
		if (eraseBit && !eraseQ) foreach (mem[i]) mem[i] <= 8'hFF;
		// Released bus toggles so a stale sample never looks like data
		flashRdData <= flashReadEnable ? mem[flashAddr[7:0]] : ~flashRdData;
	end
endmodule

// ---- verification/fsq_sequencer_monitor.sv ----
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`include "fsq_defines.vh"
module fsq_sequencer_monitor (
	input wire clock,
	input wire arst_n,
	input wire [3:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrite,
	input wire [15:0] flashAddr,
	input wire [7:0] flashWrData,
	input wire flashWrite,
	input wire flashReadEnable,
	input wire progBit,
	input wire eraseBit,
	input wire programVerifyBit,
	input wire eraseVerifyBit,
	input wire waitStateEnable,
	input wire ramEmulation
);
	logic [3:0] modeQ;
	logic [15:0] modeCnt;
	logic [15:0] wrCnt;
	logic [15:0] progHi;
	logic [15:0] addrQ;
	logic [3:0] tries;
	logic progQ;
	logic prePhase;
	wire [3:0] modes = {progBit, eraseBit, programVerifyBit, eraseVerifyBit};
	wire ctrlWr = regWrite && regAddr == `FSQ_REG_CTRL;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			modeQ <= 4'h0;
			modeCnt <= 16'h0;
			wrCnt <= 16'h0;
			progHi <= 16'h0;
			addrQ <= 16'h0;
			tries <= 4'h0;
			progQ <= 1'h0;
			prePhase <= 1'h0;
		end else begin
			modeQ <= modes;
			modeCnt <= (modes != modeQ) ? 16'h1 : modeCnt + {15'h0, ~&modeCnt};
			wrCnt <= flashWrite ? 16'h1 : wrCnt + {15'h0, ~&wrCnt};
			progHi <= progBit ? progHi + 16'h1 : 16'h0;
			progQ <= progBit;
			addrQ <= flashAddr;
			if ((ctrlWr && regWrData[0]) || flashAddr != addrQ) tries <= 4'h0;
			else if (progBit && !progQ) tries <= tries + 4'h1;
			if (ctrlWr && regWrData[1] && !regWrData[0]) prePhase <= 1'h1;
			else if (eraseBit) prePhase <= 1'h0;
		end
	end
	chk_mode_onehot: assert property ($onehot0(modes))
		else $error("more than one mode bit high");
	chk_wait_off: assert property ((|modes || flashReadEnable) |-> !waitStateEnable)
		else $error("wait states enabled during sequence");
	chk_setup_long: assert property ($rose(flashReadEnable) && !eraseVerifyBit |-> modeCnt >= 16'd160)
		else $error("read before long verify setup");
	chk_setup_short: assert property ($rose(flashReadEnable) && eraseVerifyBit |-> wrCnt >= 16'd80)
		else $error("read before short verify setup");
	chk_pulse_len: assert property (progBit |-> progHi < 16'd632)
		else $error("program pulse too long");
	chk_prog_tries: assert property (tries <= 4'h6)
		else $error("too many program pulses");
	chk_prewrite_zero: assert property (flashWrite && prePhase |-> flashWrData == 8'h00)
		else $error("prewrite data not zero");
	chk_emul_zero: assert property (flashWrite && prePhase && ramEmulation |=> $past(flashWrData) == 8'h00)
		else $error("emulated prewrite data not zero");
	chk_verify_low: assert property ($fell(progBit) && prePhase |-> (modes == 4'h0)[*8])
		else $error("mode bits not low in prewrite verify");
endmodule

// ---- verification/fsq_sequencer_tb_top.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "fsq_defines.vh"
`define CHECK_EQ(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module fsq_sequencer_tb_top;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWrite = 1'h0;
	logic regRead = 1'h0;
	logic rdPend = 1'h0;
	logic stuckEn = 1'h0;
	logic [7:0] stuckAddr = 8'h80;
	logic [7:0] data;
	logic [31:0] e;
	logic [31:0] m;
	logic [31:0] expQ[$];
	logic [31:0] maskQ[$];
	string nameQ[$];
	string s;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 51348;
	int base;
	int i;
	int p;
	int k;
	wire [31:0] regRdData;
	wire irq;
	wire [15:0] flashAddr;
	wire [7:0] flashWrData;
	wire [7:0] flashRdData;
	wire flashWrite, flashReadEnable, progBit, eraseBit, programVerifyBit, eraseVerifyBit;
	wire waitStateEnable, ramEmulation;
	int zeroProgs, progPulses;
	logic [3:0] rstA [0:7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h2, 4'hB, 4'hC};
	logic [31:0] rstE [0:7] = '{32'h278, 32'h32, 32'hA0, 32'h50, 32'hA57F, 32'h0, 32'h0, 32'h0};
	logic [31:0] profE [0:11] = '{32'h1F, 32'h1869, 32'hB, 32'h6, 32'h6, 32'h516, 32'h3, 32'h2,
		32'h4C, 32'h3D08, 32'h1C, 32'h10};
	always #12.5 clock = ~clock;
	// Long counts shortened so the whole run stays short
	fsq_sequencer #(.ERASE_PULSE_CYC(50), .PROG_TOTAL_CYC(40000), .ERASE_TOTAL_CYC(100000),
		.GUARD_DIV(4), .LOOP_DIV(2)) u_dut (.clock(clock), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .irq(irq), .flashAddr(flashAddr), .flashWrData(flashWrData),
		.flashWrite(flashWrite), .flashReadEnable(flashReadEnable), .flashRdData(flashRdData),
		.progBit(progBit), .eraseBit(eraseBit), .programVerifyBit(programVerifyBit),
		.eraseVerifyBit(eraseVerifyBit), .waitStateEnable(waitStateEnable),
		.ramEmulation(ramEmulation));
	fsq_flash_model u_model (.clock(clock), .flashAddr(flashAddr), .flashWrData(flashWrData),
		.flashWrite(flashWrite), .flashReadEnable(flashReadEnable), .progBit(progBit),
		.eraseBit(eraseBit), .stuckEn(stuckEn), .stuckAddr(stuckAddr), .flashRdData(flashRdData),
		.zeroProgs(zeroProgs), .progPulses(progPulses));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic regWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'h1;
		@(posedge clock);
		regWrite <= 1'h0;
	endtask
	task automatic regRd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk,
		input string nm);
		@(posedge clock);
		expQ.push_back(ex);
		maskQ.push_back(mk);
		nameQ.push_back(nm);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge clock);
		regRead <= 1'h0;
	endtask
	task automatic waitIrq(input string nm);
		int n;
		for (n = 0; n < 20000 && irq !== 1'h1; n++) @(posedge clock);
		`CHECK_EQ(nm, 1'h1, irq)
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		rdPend <= regRead;
		if (rdPend) begin
			e = expQ.pop_front();
			m = maskQ.pop_front();
			s = nameQ.pop_front();
			`CHECK_EQ(s, e, regRdData & m)
		end
	end
	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge clock);
		arst_n <= 1'h1;
		foreach (rstA[j]) regRd(rstA[j], rstE[j], 32'hFFFFFFFF, "reset value");
		data = 8'($random(seed)) & 8'h7F;
		// Upper half keeps the stuck byte clear of the programmed ones
		stuckAddr <= 8'($random(seed)) | 8'h80;
		regWr(`FSQ_REG_MASK, 32'h1);
		regWr(`FSQ_REG_START, 32'h10);
		regWr(`FSQ_REG_DATA, {24'h0, data});
		regWr(`FSQ_REG_CTRL, 32'h5);
		waitIrq("program done irq");
		`CHECK_EQ("programmed byte", data, u_model.mem[8'h10])
		regWr(`FSQ_REG_MASK, 32'h0);
		repeat (2) @(negedge clock);
		`CHECK_EQ("masked irq", 1'h0, irq)
		`CHECK_EQ("wait states after run", 1'h1, waitStateEnable)
		regWr(`FSQ_REG_MASK, 32'h1F);
		repeat (2) @(negedge clock);
		`CHECK_EQ("unmasked irq", 1'h1, irq)
		regRd(`FSQ_REG_STATUS, 32'h1, 32'h1F, "status done");
		repeat (2) @(negedge clock);
		`CHECK_EQ("irq after clear", 1'h0, irq)
		// Stuck byte never verifies, so every retry is spent
		stuckEn <= 1'h1;
		base = progPulses;
		regWr(`FSQ_REG_START, {24'h0, stuckAddr});
		regWr(`FSQ_REG_CTRL, 32'h1);
		waitIrq("program fail irq");
		`CHECK_EQ("program pulses", 6, progPulses - base)
		regRd(`FSQ_REG_STATUS, 32'h2, 32'h1E, "status program fail");
		stuckEn <= 1'h0;
		base = zeroProgs;
		regWr(`FSQ_REG_START, 32'h10);
		regWr(`FSQ_REG_END, 32'h13);
		regWr(`FSQ_REG_CTRL, 32'hA);
		waitIrq("erase done irq");
		`CHECK_EQ("prewrite count", 4, zeroProgs - base)
		for (i = 16; i < 20; i++) `CHECK_EQ("erased byte", 8'hFF, u_model.mem[i[7:0]])
		`CHECK_EQ("emulation flag", 1'h1, ramEmulation)
		regRd(`FSQ_REG_STATUS, 32'h1, 32'h1F, "status erase done");
		regWr(`FSQ_REG_CTRL, 32'h80);
		regRd(`FSQ_REG_GUARD, 32'hA57E, 32'hFFFF, "slow guard preset");
		regWr(`FSQ_REG_CTRL, 32'h0);
		regRd(`FSQ_REG_GUARD, 32'hA57F, 32'hFFFF, "fast guard preset");
		for (p = 1; p < 4; p++) begin
			regWr(`FSQ_REG_CTRL, {26'h0, p[1:0], 4'h0} | 32'h40);
			for (k = 0; k < 4; k++) regRd(`FSQ_REG_PROGCNT + k[3:0], profE[(p-1)*4+k], 32'hFFFFFFFF, "profile count");
		end
		repeat (3) @(posedge clock);
		finish_test();
	end
endmodule
bind fsq_sequencer fsq_sequencer_monitor u_mon (.clock(clock), .arst_n(arst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .flashAddr(flashAddr),
	.flashWrData(flashWrData), .flashWrite(flashWrite), .flashReadEnable(flashReadEnable),
	.progBit(progBit), .eraseBit(eraseBit), .programVerifyBit(programVerifyBit),
	.eraseVerifyBit(eraseVerifyBit), .waitStateEnable(waitStateEnable),
	.ramEmulation(ramEmulation));
